// File: hdl/bsiu_core.sv
// bsiu_core: bit operation and compare/step-and-skip execution with its own state
// assumes: single 20 MHz clock, synchronous pins, avalon-mm slave with waitrequest
// Function
// [RULE_01] clear-port-bit drives chosen port bit low, others and flags kept
// [RULE_02] set-port-bit drives chosen port bit high, others and flags kept
// [RULE_03] swap-with-carry exchanges port bit and carry, only carry flag changes
// [RULE_04] output port bit receives the previous carry on swap
// [RULE_05] input port bit: sampled pin level is loaded into carry
// [RULE_06] compares set all four flags as accumulator minus operand
// [RULE_07] skip-if-equal compare skips next instruction when values equal
// [RULE_08] skip-if-not-equal compare skips next instruction when values differ
// [RULE_09] test-port-bit-low skips when port bit reads 0, flags kept
// [RULE_10] test-port-bit-high skips when port bit reads 1, flags kept
// [RULE_11] memory bit tests skip on 0 or 1 form, flags kept
// [RULE_12] increment accumulator, update flags, skip when result zero
// [RULE_13] decrement accumulator, update flags, skip when result zero
// [RULE_14] increment memory byte, write back, update flags, skip on zero
// [RULE_15] decrement memory byte, write back, update flags, skip on zero
// [RULE_16] memory bit clear/set forces chosen bit, others and flags kept
// [RULE_17] skipped instruction has no effect; compares keep accumulator
// [RULE_18] increment and decrement wrap modulo 256
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
module bsiu_core import bsiu_pkg::*; (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [7:0]  port_pin,
  output logic      [7:0]  port_out,
  output logic      [7:0]  port_oe,
  output logic             skip_pending
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  accumulator_ff, nxt_accumulator;
  logic        zero_flag_ff, carry_flag_ff, aux_carry_flag_ff, overflow_flag_ff;
  logic [3:0]  nxt_flags;
  logic [7:0]  port_out_ff, nxt_port_out;
  logic [7:0]  port_dir_ff, nxt_port_dir;
  logic        skip_ff, nxt_skip;
  logic [7:0]  mem_ff [MEM_DEPTH];
  logic [7:0]  nxt_mem_byte;
  logic        mem_we;
  logic        ack_ff;
  logic [31:0] rdata_ff;

  // bus decode
  wire         bus_req   = avs_read | avs_write;
  wire         bus_wr    = avs_write & ack_ff;
  wire         lane0     = avs_byteenable[0];
  wire [31:0]  wmask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0]  wdata     = avs_writedata & wmask;
  wire         hit_mem   = avs_address[7:6] == OFS_MEM[7:6];
  wire [MEM_AW-1:0] bus_idx = avs_address[MEM_AW+1:2];
  wire         wr_cmd    = bus_wr & (avs_address == OFS_CMD);
  wire         wr_acc    = bus_wr & lane0 & (avs_address == OFS_ACC);
  wire         wr_flags  = bus_wr & lane0 & (avs_address == OFS_FLAGS);
  wire         wr_port   = bus_wr & lane0 & (avs_address == OFS_PORT_OUT);
  wire         wr_dir    = bus_wr & lane0 & (avs_address == OFS_PORT_DIR);
  wire         wr_mem    = bus_wr & lane0 & hit_mem;
  wire [3:0]   flags     = {overflow_flag_ff, aux_carry_flag_ff, carry_flag_ff, zero_flag_ff};

  // command fields
  wire [4:0]        op      = wdata[CMD_OP_LSB +: 5];
  wire [2:0]        bsel    = wdata[CMD_BIT_LSB +: 3];
  wire [MEM_AW-1:0] madr    = wdata[CMD_ADR_LSB +: MEM_AW];
  wire [7:0]        imm     = wdata[CMD_IMM_LSB +: 8];
  wire [7:0]        mbyte   = mem_ff[madr];
  wire [7:0]        port_rd = (port_dir_ff & port_out_ff) | (~port_dir_ff & port_pin);
  wire              exec    = wr_cmd & ~skip_ff; // [RULE_17]
  wire              absorb  = wr_cmd & skip_ff;  // [RULE_17]

  ////////////////////////////////////////////////////////////////////////////
  // shared adder: x + y or x - y, eight bits wide, wrapping
  logic [7:0] alu_x, alu_y;
  logic       alu_sub;
  wire  [7:0] alu_yy  = alu_y ^ {8{alu_sub}};
  wire  [8:0] alu_sum = {1'b0, alu_x} + {1'b0, alu_yy} + {8'h00, alu_sub};
  wire  [4:0] alu_nib = {1'b0, alu_x[3:0]} + {1'b0, alu_yy[3:0]} + {4'h0, alu_sub};
  wire  [7:0] alu_res = alu_sum[7:0]; // [RULE_18]
  wire  [3:0] alu_flg = {(alu_x[7] == alu_yy[7]) & (alu_res[7] != alu_x[7]),
                         alu_nib[4] ^ alu_sub, alu_sum[8] ^ alu_sub, alu_res == 8'h00};

  always_comb begin
    alu_x   = accumulator_ff;
    alu_y   = imm;
    alu_sub = 1'b1;
    case (op)
      OP_CEQ_MEM, OP_CNEQ_MEM: alu_y = mbyte;
      OP_INC_ACC_SKIP: begin
        alu_y   = 8'h01;
        alu_sub = 1'b0;
      end
      OP_DEC_ACC_SKIP: alu_y = 8'h01;
      OP_INC_MEM_SKIP: begin
        alu_x   = mbyte;
        alu_y   = 8'h01;
        alu_sub = 1'b0;
      end
      OP_DEC_MEM_SKIP: begin
        alu_x = mbyte;
        alu_y = 8'h01;
      end
      default: alu_y = imm;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // execution: next architectural state
  always_comb begin
    nxt_accumulator = wr_acc   ? wdata[7:0] : accumulator_ff;
    nxt_flags       = wr_flags ? wdata[3:0] : flags;
    nxt_port_out    = wr_port  ? wdata[7:0] : port_out_ff;
    nxt_port_dir    = wr_dir   ? wdata[7:0] : port_dir_ff;
    nxt_skip        = absorb   ? 1'b0 : skip_ff;
    nxt_mem_byte    = mbyte;
    mem_we          = 1'b0;
    if (exec) begin
      nxt_skip = 1'b0;
      case (op)
        OP_CLEAR_BIT_IO: nxt_port_out[bsel] = 1'b0; // [RULE_01]
        OP_FORCE_BIT_IO: nxt_port_out[bsel] = 1'b1; // [RULE_02]
        OP_SWAP_CARRY_IO: begin
          nxt_flags[FLG_C] = port_rd[bsel]; // [RULE_03] [RULE_05]
          if (port_dir_ff[bsel]) begin
            nxt_port_out[bsel] = carry_flag_ff; // [RULE_04]
          end
        end
        OP_CLEAR_BIT_MEM: begin
          nxt_mem_byte[bsel] = 1'b0; // [RULE_16]
          mem_we             = 1'b1;
        end
        OP_FORCE_BIT_MEM: begin
          nxt_mem_byte[bsel] = 1'b1; // [RULE_16]
          mem_we             = 1'b1;
        end
        OP_CEQ_IMM, OP_CEQ_MEM: begin
          nxt_flags = alu_flg;            // [RULE_06]
          nxt_skip  = alu_flg[FLG_Z];     // [RULE_07]
        end
        OP_CNEQ_IMM, OP_CNEQ_MEM: begin
          nxt_flags = alu_flg;            // [RULE_06]
          nxt_skip  = ~alu_flg[FLG_Z];    // [RULE_08]
        end
        OP_TEST_LOW_IO:   nxt_skip = ~port_rd[bsel]; // [RULE_09]
        OP_TEST_HIGH_IO:  nxt_skip = port_rd[bsel];  // [RULE_10]
        OP_TEST_LOW_MEM:  nxt_skip = ~mbyte[bsel];   // [RULE_11]
        OP_TEST_HIGH_MEM: nxt_skip = mbyte[bsel];    // [RULE_11]
        OP_INC_ACC_SKIP, OP_DEC_ACC_SKIP: begin
          nxt_accumulator = alu_res;        // [RULE_12] [RULE_13]
          nxt_flags       = alu_flg;
          nxt_skip        = alu_flg[FLG_Z];
        end
        OP_INC_MEM_SKIP, OP_DEC_MEM_SKIP: begin
          nxt_mem_byte = alu_res;           // [RULE_14] [RULE_15]
          mem_we       = 1'b1;
          nxt_flags    = alu_flg;
          nxt_skip     = alu_flg[FLG_Z];
        end
        default: nxt_skip = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, read data registered
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_mem) begin
      rd_mux[7:0] = mem_ff[bus_idx];
    end else begin
      case (avs_address)
        OFS_ACC:      rd_mux[7:0] = accumulator_ff;
        OFS_FLAGS:    rd_mux[3:0] = flags;
        OFS_PORT_OUT: rd_mux[7:0] = port_out_ff;
        OFS_PORT_DIR: rd_mux[7:0] = port_dir_ff;
        OFS_PORT_PIN: rd_mux[7:0] = port_pin;
        OFS_STATUS:   rd_mux[0]   = skip_ff;
        default:      rd_mux      = 32'h0000_0000;
      endcase
    end
  end

  assign avs_waitrequest = bus_req & ~ack_ff;
  assign avs_readdata    = rdata_ff;
  assign port_out        = port_out_ff;
  assign port_oe         = port_dir_ff;
  assign skip_pending    = skip_ff;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      if (avs_read & ~ack_ff) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      accumulator_ff <= RST_ACC;
      {overflow_flag_ff, aux_carry_flag_ff, carry_flag_ff, zero_flag_ff} <= RST_FLAGS;
      port_out_ff    <= RST_PORT;
      port_dir_ff    <= RST_DIR;
      skip_ff        <= 1'b0;
    end else begin
      accumulator_ff <= nxt_accumulator;
      {overflow_flag_ff, aux_carry_flag_ff, carry_flag_ff, zero_flag_ff} <= nxt_flags;
      port_out_ff    <= nxt_port_out;
      port_dir_ff    <= nxt_port_dir;
      skip_ff        <= nxt_skip;
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < MEM_DEPTH; i++) begin
      if (!rst_n) begin
        mem_ff[i] <= RST_MEM;
      end else if (mem_we && madr == i[MEM_AW-1:0]) begin
        mem_ff[i] <= nxt_mem_byte;
      end else if (wr_mem && bus_idx == i[MEM_AW-1:0]) begin
        mem_ff[i] <= wdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_CLEAR_PORT: assert property (exec && op == OP_CLEAR_BIT_IO |=> // RULE_01
    port_out_ff == ($past(port_out_ff) & ~(8'h01 << $past(bsel))) && flags == $past(flags))
    else $error("port bit clear wrong");
  AST_FORCE_PORT: assert property (exec && op == OP_FORCE_BIT_IO |=> // RULE_02
    port_out_ff == ($past(port_out_ff) | (8'h01 << $past(bsel))) && flags == $past(flags))
    else $error("port bit set wrong");
  AST_SWAP_FLAGS: assert property (exec && op == OP_SWAP_CARRY_IO |=> // RULE_03
    {overflow_flag_ff, aux_carry_flag_ff, zero_flag_ff} == $past({overflow_flag_ff,
    aux_carry_flag_ff, zero_flag_ff})) else $error("swap touched other flags");
  AST_SWAP_OUT: assert property (exec && op == OP_SWAP_CARRY_IO && port_dir_ff[bsel] // RULE_04
    |=> port_out_ff[$past(bsel)] == $past(carry_flag_ff)) else $error("swap output wrong");
  AST_SWAP_IN: assert property (exec && op == OP_SWAP_CARRY_IO && !port_dir_ff[bsel] // RULE_05
    |=> carry_flag_ff == $past(port_pin[bsel])) else $error("swap input wrong");
  AST_CMP_ACC: assert property (exec && (op == OP_CEQ_IMM || op == OP_CNEQ_IMM) // RULE_06
    |=> accumulator_ff == $past(accumulator_ff)
        && carry_flag_ff == ($past(accumulator_ff) < $past(imm))) else $error("compare wrong");
  AST_CEQ_SKIP: assert property (exec && op == OP_CEQ_IMM // RULE_07
    |=> skip_pending == ($past(accumulator_ff) == $past(imm))) else $error("ceq skip wrong");
  AST_CNEQ_SKIP: assert property (exec && op == OP_CNEQ_MEM // RULE_08
    |=> skip_pending == ($past(accumulator_ff) != $past(mbyte))) else $error("cneq skip wrong");
  AST_TEST_IO: assert property (exec && op == OP_TEST_LOW_IO // RULE_09
    |=> skip_pending == !$past(port_rd[bsel]) && flags == $past(flags))
    else $error("port test wrong");
  AST_INC_WRAP: assert property (exec && op == OP_INC_ACC_SKIP && accumulator_ff == 8'hFF // RULE_18
    |=> accumulator_ff == 8'h00 && skip_pending && zero_flag_ff) else $error("wrap wrong");
  AST_SKIP_VOID: assert property (absorb && !wr_acc |=> // RULE_17
    !skip_pending && accumulator_ff == $past(accumulator_ff) && flags == $past(flags)
    && port_out_ff == $past(port_out_ff)) else $error("skipped command had effect");
  AST_BUS_ONE_WAIT: assert property (bus_req && !ack_ff |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_TEST_IO_HIGH: assert property (exec && op == OP_TEST_HIGH_IO // RULE_10
    |=> skip_pending == $past(port_rd[bsel]) && flags == $past(flags))
    else $error("port high test wrong");
  AST_TEST_MEM_LOW: assert property (exec && op == OP_TEST_LOW_MEM // RULE_11
    |=> skip_pending == !$past(mbyte[bsel]) && flags == $past(flags))
    else $error("memory low test wrong");
  AST_TEST_MEM_HIGH: assert property (exec && op == OP_TEST_HIGH_MEM // RULE_11
    |=> skip_pending == $past(mbyte[bsel]) && flags == $past(flags))
    else $error("memory high test wrong");
  AST_INC_ACC: assert property (exec && op == OP_INC_ACC_SKIP // RULE_12
    |=> accumulator_ff == 8'($past(accumulator_ff) + 8'h01)
        && skip_pending == (accumulator_ff == 8'h00) && zero_flag_ff == skip_pending)
    else $error("acc increment wrong");
  AST_DEC_ACC: assert property (exec && op == OP_DEC_ACC_SKIP // RULE_13
    |=> accumulator_ff == 8'($past(accumulator_ff) - 8'h01)
        && skip_pending == (accumulator_ff == 8'h00) && zero_flag_ff == skip_pending
        && carry_flag_ff == ($past(accumulator_ff) == 8'h00)) else $error("acc decrement wrong");
  AST_INC_MEM: assert property (exec && op == OP_INC_MEM_SKIP // RULE_14
    |=> mem_ff[$past(madr)] == 8'($past(mbyte) + 8'h01)
        && skip_pending == (mem_ff[$past(madr)] == 8'h00) && zero_flag_ff == skip_pending)
    else $error("memory increment wrong");
  AST_DEC_MEM: assert property (exec && op == OP_DEC_MEM_SKIP // RULE_15
    |=> mem_ff[$past(madr)] == 8'($past(mbyte) - 8'h01)
        && skip_pending == (mem_ff[$past(madr)] == 8'h00)
        && carry_flag_ff == ($past(mbyte) == 8'h00)) else $error("memory decrement wrong");
  AST_CLR_MEM_BIT: assert property (exec && op == OP_CLEAR_BIT_MEM // RULE_16
    |=> mem_ff[$past(madr)] == ($past(mbyte) & ~(8'h01 << $past(bsel)))
        && flags == $past(flags)) else $error("memory bit clear wrong");
  AST_SET_MEM_BIT: assert property (exec && op == OP_FORCE_BIT_MEM // RULE_16
    |=> mem_ff[$past(madr)] == ($past(mbyte) | (8'h01 << $past(bsel)))
        && flags == $past(flags)) else $error("memory bit set wrong");
  AST_CEQ_MEM_SKIP: assert property (exec && op == OP_CEQ_MEM // RULE_07
    |=> skip_pending == ($past(accumulator_ff) == $past(mbyte))) else $error("ceq mem wrong");

  COV_SKIP_TAKEN: cover property (exec && op == OP_CEQ_MEM ##1 skip_pending ##[1:20] absorb);
  COV_SWAP_OUT:   cover property (exec && op == OP_SWAP_CARRY_IO && port_dir_ff[bsel]);
  COV_DEC_MEM_0:  cover property (exec && op == OP_DEC_MEM_SKIP && mbyte == 8'h01);
  COV_INC_WRAP:   cover property (exec && op == OP_INC_ACC_SKIP && accumulator_ff == 8'hFF);
endmodule // bsiu_core

// File: hdl/bsiu_pkg.sv
// bsiu_pkg: offsets, opcodes, field positions and reset values of the bit and skip unit
// assumes: 32-bit avalon-mm slave with byte addresses, 20 MHz clock
package bsiu_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_ACC      = 8'h04;
  localparam logic [7:0] OFS_FLAGS    = 8'h08;
  localparam logic [7:0] OFS_PORT_OUT = 8'h0C;
  localparam logic [7:0] OFS_PORT_DIR = 8'h10;
  localparam logic [7:0] OFS_PORT_PIN = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_MEM      = 8'h40;
  localparam int         MEM_DEPTH    = 16;
  localparam int         MEM_AW       = 4;
  // command word fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_BIT_LSB = 8;
  localparam int CMD_ADR_LSB = 12;
  localparam int CMD_IMM_LSB = 16;
  // flags register bit positions
  localparam int FLG_Z  = 0;
  localparam int FLG_C  = 1;
  localparam int FLG_AC = 2;
  localparam int FLG_OV = 3;
  // reset values
  localparam logic [7:0] RST_ACC   = 8'h00;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [7:0] RST_PORT  = 8'h00;
  localparam logic [7:0] RST_DIR   = 8'h00;
  localparam logic [7:0] RST_MEM   = 8'h00;
  // opcodes
  localparam logic [4:0] OP_NOP            = 5'h00;
  localparam logic [4:0] OP_CLEAR_BIT_IO   = 5'h01;
  localparam logic [4:0] OP_FORCE_BIT_IO   = 5'h02;
  localparam logic [4:0] OP_SWAP_CARRY_IO  = 5'h03;
  localparam logic [4:0] OP_CLEAR_BIT_MEM  = 5'h04;
  localparam logic [4:0] OP_FORCE_BIT_MEM  = 5'h05;
  localparam logic [4:0] OP_CEQ_IMM        = 5'h06;
  localparam logic [4:0] OP_CEQ_MEM        = 5'h07;
  localparam logic [4:0] OP_CNEQ_IMM       = 5'h08;
  localparam logic [4:0] OP_CNEQ_MEM       = 5'h09;
  localparam logic [4:0] OP_TEST_LOW_IO    = 5'h0A;
  localparam logic [4:0] OP_TEST_HIGH_IO   = 5'h0B;
  localparam logic [4:0] OP_TEST_LOW_MEM   = 5'h0C;
  localparam logic [4:0] OP_TEST_HIGH_MEM  = 5'h0D;
  localparam logic [4:0] OP_INC_ACC_SKIP   = 5'h0E;
  localparam logic [4:0] OP_DEC_ACC_SKIP   = 5'h0F;
  localparam logic [4:0] OP_INC_MEM_SKIP   = 5'h10;
  localparam logic [4:0] OP_DEC_MEM_SKIP   = 5'h11;
endpackage : bsiu_pkg

// File: verification/bsiu_core_tb_top.sv
// bsiu_core_tb_top: self-checking bench with a reference model of the bit and skip unit
// assumes: bsiu_pkg compiled first, bsiu_core is the device, 20 MHz clock
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module bsiu_core_tb_top import bsiu_pkg::*;;
  logic        clock;
  logic        rst_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  port_pin;
  logic [7:0]  port_out;
  logic [7:0]  port_oe;
  logic        skip_pending;
  int          errors;
  int          total_checks;
  logic [7:0]  m_acc, m_out, m_dir;
  logic [7:0]  m_mem [MEM_DEPTH];
  logic [3:0]  m_flg;
  logic        m_skip;
  logic [7:0]  tbl [6] = '{8'h00, 8'hFF, 8'h7F, 8'h80, 8'h0F, 8'h10};
  bsiu_core u_bsiu_core (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_pin(port_pin), .port_out(port_out),
    .port_oe(port_oe), .skip_pending(skip_pending));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one bus transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      errors++;
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    xfer(1'b1, a, d, be, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
    `CHK(q, e)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // flags as a+y (add) or a-y
  task automatic alu(input logic [7:0] x, input logic [7:0] y, input bit add,
                     output logic [7:0] r);
    int s;
    s = add ? int'(x) + int'(y) : int'(x) - int'(y);
    r = s[7:0];
    m_flg[FLG_Z] = (r == 8'h00);
    m_flg[FLG_C] = add ? (s > 255) : (x < y);
    m_flg[FLG_AC] = add ? (x[3:0] + y[3:0] > 15) : (x[3:0] < y[3:0]);
    m_flg[FLG_OV] = (add ? (x[7] == y[7]) : (x[7] != y[7])) && (r[7] != x[7]);
  endtask
  task automatic exec(input logic [31:0] c);
    logic [4:0] op;
    logic [2:0] b;
    logic [3:0] i;
    logic [7:0] y, r;
    logic       rb, oc, sk;
    op = c[4:0];
    b = c[10:8];
    i = c[15:12];
    rb = m_dir[b] ? m_out[b] : port_pin[b];
    sk = 1'b0;
    if (m_skip) begin
      m_skip = 1'b0;
      return;
    end
    case (op)
      OP_CLEAR_BIT_IO: m_out[b] = 1'b0;
      OP_FORCE_BIT_IO: m_out[b] = 1'b1;
      OP_SWAP_CARRY_IO: begin
        oc = m_flg[FLG_C];
        m_flg[FLG_C] = rb;
        if (m_dir[b]) m_out[b] = oc;
      end
      OP_CLEAR_BIT_MEM: m_mem[i][b] = 1'b0;
      OP_FORCE_BIT_MEM: m_mem[i][b] = 1'b1;
      OP_CEQ_IMM, OP_CEQ_MEM, OP_CNEQ_IMM, OP_CNEQ_MEM: begin
        y = (op == OP_CEQ_IMM || op == OP_CNEQ_IMM) ? c[23:16] : m_mem[i];
        alu(m_acc, y, 1'b0, r);
        sk = (op < OP_CNEQ_IMM) ? (m_acc == y) : (m_acc != y);
      end
      OP_TEST_LOW_IO: sk = ~rb;
      OP_TEST_HIGH_IO: sk = rb;
      OP_TEST_LOW_MEM: sk = ~m_mem[i][b];
      OP_TEST_HIGH_MEM: sk = m_mem[i][b];
      OP_INC_ACC_SKIP, OP_DEC_ACC_SKIP: begin
        alu(m_acc, 8'h01, op == OP_INC_ACC_SKIP, m_acc);
        sk = (m_acc == 8'h00);
      end
      OP_INC_MEM_SKIP, OP_DEC_MEM_SKIP: begin
        alu(m_mem[i], 8'h01, op == OP_INC_MEM_SKIP, m_mem[i]);
        sk = (m_mem[i] == 8'h00);
      end
      default: sk = 1'b0;
    endcase
    m_skip = sk;
  endtask
  task automatic check_all(input logic [3:0] i);
    rd_chk(OFS_ACC, {24'h0, m_acc});
    rd_chk(OFS_FLAGS, {28'h0, m_flg});
    rd_chk(OFS_PORT_OUT, {24'h0, m_out});
    rd_chk(OFS_PORT_DIR, {24'h0, m_dir});
    rd_chk(OFS_MEM + {2'b00, i, 2'b00}, {24'h0, m_mem[i]});
    rd_chk(OFS_STATUS, {31'h0, m_skip});
    `CHK({24'h0, port_out}, {24'h0, m_out})
    `CHK({24'h0, port_oe}, {24'h0, m_dir})
    `CHK({31'h0, skip_pending}, {31'h0, m_skip})
  endtask
  function automatic logic [7:0] pick();
    int k;
    k = $urandom % 8;
    return (k < 6) ? tbl[k] : 8'($urandom);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] c;
    logic [3:0]  i, be;
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    port_pin = 8'h00;
    errors = 0;
    total_checks = 0;
    m_acc = RST_ACC;
    m_out = RST_PORT;
    m_dir = RST_DIR;
    m_flg = RST_FLAGS;
    m_skip = 1'b0;
    foreach (m_mem[k]) m_mem[k] = RST_MEM;
    void'($urandom(32'h1c142502));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    check_all(4'h0);
    rd_chk(8'h30, 32'h0);
    wr(8'h34, 32'hFFFF_FFFF, 4'hF);
    rd_chk(OFS_CMD, 32'h0);
    for (int n = 0; n < 400; n++) begin
      i = 4'($urandom);
      be = ($urandom % 4 == 0) ? 4'hE : 4'hF;
      c = {24'h0, pick()};
      wr(OFS_ACC, c, be);
      if (be[0]) m_acc = c[7:0];
      m_flg = 4'($urandom);
      wr(OFS_FLAGS, {28'h0, m_flg}, 4'hF);
      m_out = 8'($urandom);
      wr(OFS_PORT_OUT, {24'h0, m_out}, 4'hF);
      m_dir = 8'($urandom);
      wr(OFS_PORT_DIR, {24'h0, m_dir}, 4'hF);
      m_mem[i] = ($urandom % 3 == 0) ? m_acc : pick();
      wr(OFS_MEM + {2'b00, i, 2'b00}, {24'h0, m_mem[i]}, 4'hF);
      port_pin <= 8'($urandom);
      c = {8'h0, ($urandom % 2) ? m_acc : pick(), i, 1'b0, 3'($urandom), 3'b000,
           5'($urandom % 20)};
      wr(OFS_CMD, c, 4'hF);
      exec(c);
      rd_chk(OFS_PORT_PIN, {24'h0, port_pin});
      check_all(i);
    end
    close_out();
  end
endmodule // bsiu_core_tb_top
